// >>> inc/calq_pkg.sv
`default_nettype none
package calq_pkg;
  // Register indices; the byte address on the bus is index * 4
  localparam logic [15:0] CALQ_IDX_CONFIG = 16'h222C;
  localparam logic [15:0] CALQ_IDX_THRESH = 16'h222D;
  localparam logic [15:0] CALQ_IDX_QCTRL = 16'h227E;
  localparam logic [15:0] CALQ_IDX_QRES = 16'h227F;
  localparam logic [15:0] CALQ_IDX_ANT = 16'h2284;
  localparam logic [15:0] CALQ_IDX_PKT = 16'h2285;
  localparam logic [15:0] CALQ_IDX_IRQ_STAT = 16'h2300;
  localparam logic [15:0] CALQ_IDX_IRQ_MASK = 16'h2301;
  localparam int CALQ_ADDR_W = 18;
  // Field positions
  localparam int CALQ_FIX_BIT = 5;
  localparam int CALQ_AWS_LSB = 2;
  localparam int CALQ_QUALITY_ESTIMATE_ENABLE_BIT = 3;
  localparam int CALQ_QUALITY_VALID_FLAG_BIT = 7;
  // Reset values
  localparam logic [7:0] CALQ_CONFIG_RST = 8'h20;
  localparam logic [7:0] CALQ_THRESH_RST = 8'hB2;
  localparam logic [7:0] CALQ_QCTRL_RST = 8'h00;
  localparam logic [7:0] CALQ_STAT_RST = 8'h00;
  // Interrupt status bits
  localparam int CALQ_IRQ_LQI = 0;
  localparam int CALQ_IRQ_PKT = 1;
  localparam int CALQ_IRQ_BUSY = 2;
  // Timing
  localparam int CALQ_CLK_MHZ = 25;
  localparam int CALQ_WIN_US_0 = 1;
  localparam int CALQ_WIN_US_1 = 2;
  localparam int CALQ_WIN_US_2 = 4;
  localparam int CALQ_WIN_US_3 = 8;
  localparam int CALQ_WIN_US_X = 16;
  localparam int CALQ_LQI_SYMBOLS = 8;
  typedef enum logic [1:0] {
    CALQ_ED = 2'b00,
    CALQ_CD = 2'b01,
    CALQ_FD = 2'b10,
    CALQ_RSV = 2'b11
  } calq_method_e;
  typedef enum logic [1:0] {
    CALQ_Q_IDLE = 2'b00,
    CALQ_Q_ACC = 2'b01,
    CALQ_Q_DONE = 2'b10
  } calq_qstate_e;
endpackage
`default_nettype wire

// >>> core/calq_energy_avg.sv
`timescale 1ns/1ps
`default_nettype none
module calq_energy_avg
  import calq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] win_sel,
  input wire logic run,
  input wire logic energy_valid,
  input wire logic signed [7:0] energy_in,
  output logic signed [7:0] avg_out,
  output logic avg_stb
);
  // =====================================================
  // Window length in cycles
  function automatic logic [8:0] win_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: win_cycles = 9'(CALQ_WIN_US_0 * CALQ_CLK_MHZ);
      3'h1: win_cycles = 9'(CALQ_WIN_US_1 * CALQ_CLK_MHZ);
      3'h2: win_cycles = 9'(CALQ_WIN_US_2 * CALQ_CLK_MHZ);
      3'h3: win_cycles = 9'(CALQ_WIN_US_3 * CALQ_CLK_MHZ);
      default: win_cycles = 9'(CALQ_WIN_US_X * CALQ_CLK_MHZ);
    endcase
  endfunction

  logic [8:0] cnt_q;
  logic [8:0] n_q;
  logic signed [17:0] sum_q;
  logic signed [17:0] acc;
  logic [8:0] n1;

  // =====================================================
  // Averaging over the selected window
  always_comb begin
    acc = sum_q + (energy_valid ? 18'(energy_in) : 18'h00000);
    n1 = n_q + (energy_valid ? 9'h001 : 9'h000);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || !run) begin
      cnt_q <= 9'h000;
      n_q <= 9'h000;
      sum_q <= 18'h00000;
      avg_out <= 8'h00;
      avg_stb <= 1'b0;
    end else if (cnt_q + 9'h001 >= win_cycles(win_sel)) begin
      cnt_q <= 9'h000;
      n_q <= 9'h000;
      sum_q <= 18'h00000;
      avg_stb <= (n1 != 9'h000);
      if (n1 != 9'h000) begin
        avg_out <= 8'(acc / $signed({9'h000, n1}));
      end
    end else begin
      cnt_q <= cnt_q + 9'h001;
      n_q <= n1;
      sum_q <= acc;
      avg_stb <= 1'b0;
    end
  end
endmodule // calq_energy_avg
`default_nettype wire

// >>> core/calq_top.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module calq_top
  import calq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [CALQ_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CALQ_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic energy_valid,
  input wire logic signed [7:0] energy_level,
  input wire logic carrier_detect,
  input wire logic frame_detect,
  input wire logic packet_active,
  input wire logic frame_start,
  input wire logic frame_fec,
  input wire logic symbol_valid,
  input wire logic [7:0] symbol_corr,
  input wire logic packet_done,
  input wire logic signed [7:0] packet_energy_level,
  input wire logic tx_request,
  output logic tx_grant,
  output logic channel_busy,
  output logic irq
);
  // =====================================================
  // Address decode
  function automatic logic [15:0] word_idx(input logic [CALQ_ADDR_W-1:0] a);
    word_idx = a[CALQ_ADDR_W-1:2];
  endfunction

  logic [7:0] config_q;
  logic [7:0] thresh_q;
  logic [7:0] qctrl_q;
  logic [7:0] qres_q;
  logic [7:0] ant_q;
  logic [7:0] pkt_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;
  logic qvalid_q;
  logic busy_q;
  logic busy_prev_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [15:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic rd_go;
  logic rd_stat;
  logic [7:0] rd_val;
  logic rd_hit;
  logic signed [7:0] avg_val;
  logic avg_stb;
  logic lqi_set;
  calq_qstate_e qstate_q;
  logic [3:0] sym_cnt_q;
  logic [10:0] corr_sum_q;
  calq_method_e method;
  logic busy_raw;

  // =====================================================
  // AXI4-Lite write path
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_idx_q <= 16'h0000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_idx_q <= word_idx(s_axi_awaddr);
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; reserved bits kept zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      config_q <= CALQ_CONFIG_RST;
      thresh_q <= CALQ_THRESH_RST;
      qctrl_q <= CALQ_QCTRL_RST;
      irq_mask_q <= 8'h00;
    end else if (wr_go && wstrb_q[0]) begin
      if (aw_idx_q == CALQ_IDX_CONFIG) begin
        config_q <= {2'b00, wdata_q[5:0]};
      end else if (aw_idx_q == CALQ_IDX_THRESH) begin
        thresh_q <= wdata_q[7:0];
      end else if (aw_idx_q == CALQ_IDX_QCTRL) begin
        qctrl_q <= {4'h0, wdata_q[CALQ_QUALITY_ESTIMATE_ENABLE_BIT], 3'h0};
      end else if (aw_idx_q == CALQ_IDX_IRQ_MASK) begin
        irq_mask_q <= {5'h00, wdata_q[2:0]};
      end
    end
  end

  // =====================================================
  // AXI4-Lite read path
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (word_idx(s_axi_araddr) == CALQ_IDX_CONFIG) begin
      rd_val = config_q;
    end else if (word_idx(s_axi_araddr) == CALQ_IDX_THRESH) begin
      rd_val = thresh_q;
    end else if (word_idx(s_axi_araddr) == CALQ_IDX_QCTRL) begin
      rd_val = {qvalid_q, qctrl_q[6:0]};
    end else if (word_idx(s_axi_araddr) == CALQ_IDX_QRES) begin
      rd_val = qres_q;
    end else if (word_idx(s_axi_araddr) == CALQ_IDX_ANT) begin
      rd_val = ant_q;
    end else if (word_idx(s_axi_araddr) == CALQ_IDX_PKT) begin
      rd_val = pkt_q;
    end else if (word_idx(s_axi_araddr) == CALQ_IDX_IRQ_STAT) begin
      rd_val = irq_stat_q;
    end else if (word_idx(s_axi_araddr) == CALQ_IDX_IRQ_MASK) begin
      rd_val = irq_mask_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign rd_stat = rd_go && (word_idx(s_axi_araddr) == CALQ_IDX_IRQ_STAT);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================
  // Channel assessment
  assign method = calq_method_e'(config_q[1:0]);

  calq_energy_avg u_avg (
    .mclk(mclk),
    .rst_b(rst_b),
    .win_sel(config_q[CALQ_AWS_LSB +: 3]),
    .run(!packet_active),
    .energy_valid(energy_valid),
    .energy_in(energy_level),
    .avg_out(avg_val),
    .avg_stb(avg_stb)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ant_q <= CALQ_STAT_RST;
    end else if (avg_stb) begin
      ant_q <= avg_val;
    end
  end

  always_comb begin
    case (method)
      CALQ_ED: busy_raw = $signed(ant_q) > $signed(thresh_q);
      CALQ_CD: busy_raw = carrier_detect;
      CALQ_FD: busy_raw = frame_detect;
      default: busy_raw = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      busy_prev_q <= 1'b0;
    end else begin
      busy_q <= busy_raw && !config_q[CALQ_FIX_BIT];
      busy_prev_q <= busy_q;
    end
  end

  assign channel_busy = busy_q;
  assign tx_grant = tx_request && !busy_q;

  // =====================================================
  // Link quality estimate
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      qstate_q <= CALQ_Q_IDLE;
      sym_cnt_q <= 4'h0;
      corr_sum_q <= 11'h000;
      qres_q <= CALQ_STAT_RST;
      qvalid_q <= 1'b0;
    end else begin
      case (qstate_q)
        CALQ_Q_IDLE, CALQ_Q_DONE: begin
          if (frame_start) begin
            qvalid_q <= 1'b0;
            sym_cnt_q <= 4'h0;
            corr_sum_q <= 11'h000;
            if (qctrl_q[CALQ_QUALITY_ESTIMATE_ENABLE_BIT] && !frame_fec) begin
              qstate_q <= CALQ_Q_ACC;
            end else begin
              qstate_q <= CALQ_Q_IDLE;
            end
          end
        end
        CALQ_Q_ACC: begin
          if (frame_start) begin
            sym_cnt_q <= 4'h0;
            corr_sum_q <= 11'h000;
          end else if (symbol_valid) begin
            corr_sum_q <= corr_sum_q + 11'(symbol_corr);
            sym_cnt_q <= sym_cnt_q + 4'h1;
            if (sym_cnt_q == 4'(CALQ_LQI_SYMBOLS - 1)) begin
              qres_q <= 8'((corr_sum_q + 11'(symbol_corr)) >> 3);
              qvalid_q <= 1'b1;
              qstate_q <= CALQ_Q_DONE;
            end
          end
        end
        default: qstate_q <= CALQ_Q_IDLE;
      endcase
    end
  end

  assign lqi_set = (qstate_q == CALQ_Q_ACC) && !frame_start && symbol_valid
    && (sym_cnt_q == 4'(CALQ_LQI_SYMBOLS - 1));

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pkt_q <= CALQ_STAT_RST;
    end else if (packet_done) begin
      pkt_q <= packet_energy_level;
    end
  end

  // =====================================================
  // Interrupts: set wins over read-clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_stat_q <= 8'h00;
    end else begin
      irq_stat_q <= (rd_stat ? 8'h00 : irq_stat_q)
        | {5'h00, busy_q && !busy_prev_q, packet_done, lqi_set};
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);
endmodule // calq_top
`default_nettype wire

// >>> sim/calq_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module calq_top_chk
  import calq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [CALQ_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic carrier_detect,
  input wire logic frame_detect,
  input wire logic tx_request,
  input wire logic tx_grant,
  input wire logic channel_busy,
  input wire logic irq
);
  logic [7:0] cfg_q;
  // ==========================================
  // Shadow of the configuration register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_q <= CALQ_CONFIG_RST;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_wstrb[0] && s_axi_awaddr == {CALQ_IDX_CONFIG, 2'b00}) begin
      cfg_q <= s_axi_wdata[7:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_mode(logic [1:0] m, logic src);
    cfg_q == $past(cfg_q) && cfg_q == $past(cfg_q, 2) && cfg_q[5:0] == {4'h0, m}
      |-> channel_busy == src;
  endproperty
  a_grant_gate: assert property (tx_grant == (tx_request && !channel_busy))
    else $error("grant not gated by busy");
  a_carrier_busy: assert property (p_mode(2'h1, $past(carrier_detect)))
    else $error("busy does not follow carrier");
  a_frame_busy: assert property (p_mode(2'h2, $past(frame_detect)))
    else $error("busy does not follow frame detect");
  a_force_idle: assert property (cfg_q[5] && $past(cfg_q[5]) && $past(cfg_q[5], 2)
      |-> !channel_busy)
    else $error("busy while forced idle");
  a_reset_quiet: assert property (!$past(rst_b) |-> !channel_busy && !irq)
    else $error("busy or irq right after reset");
  a_write_resp: assert property (s_wr_take |=> ##[0:2] s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_take |=> ##[0:1] s_axi_rvalid)
    else $error("read data missing");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule // calq_top_chk
bind calq_top calq_top_chk u_calq_top_chk (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .carrier_detect, .frame_detect, .tx_request, .tx_grant, .channel_busy, .irq);
`default_nettype wire

// >>> sim/calq_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module calq_rx_model
  import calq_pkg::*;
(
  input wire logic mclk,
  output logic energy_valid,
  output logic signed [7:0] energy_level,
  output logic carrier_detect,
  output logic frame_detect,
  output logic packet_active,
  output logic frame_start,
  output logic frame_fec,
  output logic symbol_valid,
  output logic [7:0] symbol_corr,
  output logic packet_done,
  output logic signed [7:0] packet_energy_level,
  output logic tx_request
);
  // ==========================================
  // Receive baseband and transmit scheduler
  assign energy_valid = 1'b1;
  assign tx_request = 1'b1;
  initial begin
    {energy_level, carrier_detect, frame_detect, packet_active} = 11'h000;
    {frame_start, frame_fec, symbol_valid, packet_done} = 4'h0;
    symbol_corr = 8'h5A;
    packet_energy_level = 8'hA5;
  end
  task automatic lines(input logic [7:0] e, input logic c, input logic f);
    energy_level <= e;
    carrier_detect <= c;
    frame_detect <= f;
  endtask
  // Lines outside their strobe carry inverted junk
  task automatic frame(input logic fec, input logic [7:0] c0, input logic [7:0] pe);
    @(posedge mclk);
    packet_active <= 1'b1;
    frame_start <= 1'b1;
    frame_fec <= fec;
    @(posedge mclk);
    frame_start <= 1'b0;
    frame_fec <= ~fec;
    for (int i = 0; i < 8; i++) begin
      symbol_valid <= 1'b1;
      symbol_corr <= c0 + 8'(i);
      @(posedge mclk);
      symbol_valid <= 1'b0;
      symbol_corr <= ~(c0 + 8'(i));
      @(posedge mclk);
    end
    packet_done <= 1'b1;
    packet_energy_level <= pe;
    packet_active <= 1'b0;
    @(posedge mclk);
    packet_done <= 1'b0;
    packet_energy_level <= ~pe;
  endtask
endmodule // calq_rx_model
`default_nettype wire

// >>> sim/tb_calq_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_calq_top import calq_pkg::*;;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [CALQ_ADDR_W-1:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic energy_valid, carrier_detect, frame_detect, packet_active, frame_start, frame_fec;
  logic symbol_valid, packet_done, tx_request, tx_grant, channel_busy, irq;
  logic signed [7:0] energy_level, packet_energy_level;
  logic [7:0] symbol_corr;
  int error_cnt = 0, samples_checked = 0;
  initial begin
    forever #20 mclk = ~mclk;
  end
  calq_top u_calq_top (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .energy_valid, .energy_level, .carrier_detect, .frame_detect,
    .packet_active, .frame_start, .frame_fec, .symbol_valid, .symbol_corr, .packet_done,
    .packet_energy_level, .tx_request, .tx_grant, .channel_busy, .irq);
  calq_rx_model u_calq_rx_model (.mclk, .energy_valid, .energy_level, .carrier_detect,
    .frame_detect, .packet_active, .frame_start, .frame_fec, .symbol_valid, .symbol_corr,
    .packet_done, .packet_energy_level, .tx_request);
  // ==========================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (aw || w) begin
      @(posedge mclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, 32'h0);
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdc(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr <= {i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {24'h0, e});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk({31'h0, tx_grant}, 32'h1);
    rdc(CALQ_IDX_CONFIG, 8'h20, 2'h0);
    rdc(CALQ_IDX_THRESH, 8'hB2, 2'h0);
    rdc(CALQ_IDX_QCTRL, 8'h00, 2'h0);
    rdc(CALQ_IDX_QRES, 8'h00, 2'h0);
    rdc(CALQ_IDX_ANT, 8'h00, 2'h0);
    rdc(CALQ_IDX_PKT, 8'h00, 2'h0);
    rdc(16'h0000, 8'h00, 2'h2);
  endtask
  task automatic t_modes();
    wr(CALQ_IDX_THRESH, 8'h7F);
    for (int m = 0; m < 3; m++) begin
      wr(CALQ_IDX_CONFIG, 8'(m));
      u_calq_rx_model.lines(8'h00, 1'b1, 1'b0);
      repeat (3) @(posedge mclk);
      chk({31'h0, channel_busy}, {31'h0, m == 1});
      chk({31'h0, tx_grant}, {31'h0, m != 1});
      u_calq_rx_model.lines(8'h00, 1'b0, 1'b1);
      repeat (3) @(posedge mclk);
      chk({31'h0, channel_busy}, {31'h0, m == 2});
    end
    wr(CALQ_IDX_CONFIG, 8'h22);
    repeat (3) @(posedge mclk);
    chk({31'h0, channel_busy}, 32'h0);
  endtask
  task automatic t_energy();
    wr(CALQ_IDX_THRESH, 8'h10);
    wr(CALQ_IDX_CONFIG, 8'h00);
    u_calq_rx_model.lines(8'h20, 1'b0, 1'b0);
    repeat (80) @(posedge mclk);
    rdc(CALQ_IDX_ANT, 8'h20, 2'h0);
    chk({31'h0, channel_busy}, 32'h1);
    wr(CALQ_IDX_THRESH, 8'h20);
    repeat (3) @(posedge mclk);
    chk({31'h0, channel_busy}, 32'h0);
    wr(CALQ_IDX_THRESH, 8'h10);
    u_calq_rx_model.lines(8'hEC, 1'b0, 1'b0);
    repeat (80) @(posedge mclk);
    rdc(CALQ_IDX_ANT, 8'hEC, 2'h0);
    chk({31'h0, channel_busy}, 32'h0);
    // Longest window: old average must survive well past a short window
    wr(CALQ_IDX_CONFIG, 8'h10);
    u_calq_rx_model.lines(8'h30, 1'b0, 1'b0);
    repeat (100) @(posedge mclk);
    rdc(CALQ_IDX_ANT, 8'hEC, 2'h0);
    repeat (800) @(posedge mclk);
    rdc(CALQ_IDX_ANT, 8'h30, 2'h0);
    chk({31'h0, channel_busy}, 32'h1);
  endtask
  task automatic t_lqi();
    wr(CALQ_IDX_CONFIG, 8'h20);
    wr(CALQ_IDX_QCTRL, 8'h08);
    rdc(CALQ_IDX_IRQ_STAT, 8'h04, 2'h0);
    u_calq_rx_model.frame(1'b0, 8'hF0, 8'hC8);
    rdc(CALQ_IDX_QCTRL, 8'h88, 2'h0);
    rdc(CALQ_IDX_QRES, 8'hF3, 2'h0);
    rdc(CALQ_IDX_PKT, 8'hC8, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wr(CALQ_IDX_IRQ_MASK, 8'h02);
    chk({31'h0, irq}, 32'h1);
    rdc(CALQ_IDX_IRQ_STAT, 8'h03, 2'h0);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    u_calq_rx_model.frame(1'b1, 8'h10, 8'hB0);
    rdc(CALQ_IDX_QCTRL, 8'h08, 2'h0);
    rdc(CALQ_IDX_QRES, 8'hF3, 2'h0);
    rdc(CALQ_IDX_PKT, 8'hB0, 2'h0);
    wr(CALQ_IDX_QCTRL, 8'h88);
    rdc(CALQ_IDX_QCTRL, 8'h08, 2'h0);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_modes();
    t_energy();
    t_lqi();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end
endmodule // tb_calq_top
`default_nettype wire
